/* core/drv_ctrl_decode.sv */
`timescale 1ns/1ps
module drv_ctrl_decode
    import drv_ctrl_pkg::*;
(
    // System clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    // Serial link, on its own clock
    input  wire logic              sck,
    input  wire logic              sck_rst_n,
    input  wire logic              chip_select_n,
    input  wire logic              sdi,
    // Coil current command
    output logic                   coil_a_polarity,
    output logic [MAG_W-1:0]       coil_a_magnitude,
    output logic                   coil_b_polarity,
    output logic [MAG_W-1:0]       coil_b_magnitude,
    // Step input configuration
    output logic                   step_interpolate_en,
    output logic                   both_edge_step,
    output logic [STEP_RES_W-1:0]  microstep_resolution,
    output logic [8:0]             microsteps_per_quarter,
    // Mode and diagnostics
    output logic                   step_interface_off,
    output logic                   reserved_bits_err
);
    // ------------------------------------------------------------
    // Link domain: shift register on sck
    // ------------------------------------------------------------
    logic [WORD_W-1:0] shift_r;    // Keeps only the last 20 bits
    logic [WORD_W-1:0] shift_nxt;

    // Shift on every sck rise while selected; older bits fall off the top
    always_comb begin
        shift_nxt = shift_r;
        if (!chip_select_n) begin
            shift_nxt = {shift_r[WORD_W-2:0], sdi};
        end
    end

    always_ff @(posedge sck) begin
        if (!sck_rst_n) begin
            shift_r <= '0;
        end else begin
            shift_r <= shift_nxt;
        end
    end

    // ------------------------------------------------------------
    // Crossing: chip select level, then data held stable
    // ------------------------------------------------------------
    // The shift register is quiet while chip select is high, since it
    // only shifts while selected, so the word is safe to sample then.
    logic cs_sync;
    // Synchroniser idles high like the pin, so reset makes no false rise
    sync2 #(.W(1), .RST_VAL(1'b1)) u_cs_sync (
        .clk   (ref_clk),
        .rst_n (rst_n),
        .d     (chip_select_n),
        .q     (cs_sync)
    );

    logic              cs_d_r;     // Previous synced chip select
    logic              cs_d_nxt;
    logic              cs_rise_r;  // One-cycle strobe, word ready
    logic              cs_rise_nxt;
    logic [WORD_W-1:0] word_r;     // Latched word, system domain
    logic [WORD_W-1:0] word_nxt;

    // Detect the rise on the settled copy only
    always_comb begin
        cs_d_nxt    = cs_sync;
        cs_rise_nxt = cs_sync & ~cs_d_r;
        word_nxt    = word_r;
        if (cs_sync && !cs_d_r) begin
            word_nxt = shift_r;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cs_d_r    <= 1'b1;
            cs_rise_r <= 1'b0;
            word_r    <= '0;
        end else begin
            cs_d_r    <= cs_d_nxt;
            cs_rise_r <= cs_rise_nxt;
            word_r    <= word_nxt;
        end
    end

    // ------------------------------------------------------------
    // Register select and field decode
    // ------------------------------------------------------------
    logic              is_drv_ctrl;
    logic              is_pwr_cfg;
    assign is_drv_ctrl = cs_rise_r &&
                         (word_r[ADDR_HI_BIT:ADDR_LO_BIT] == DRV_CTRL_SEL);
    assign is_pwr_cfg  = cs_rise_r &&
                         (word_r[ADDR_HI_BIT:SEL3_BIT] == PWR_CFG_SEL);

    logic                  off_r, off_nxt;
    logic                  pol_a_r, pol_a_nxt;
    logic [MAG_W-1:0]      mag_a_r, mag_a_nxt;
    logic                  pol_b_r, pol_b_nxt;
    logic [MAG_W-1:0]      mag_b_r, mag_b_nxt;
    logic                  interp_r, interp_nxt;
    logic                  both_edge_r, both_edge_nxt;
    logic [STEP_RES_W-1:0] step_res_r, step_res_nxt;
    logic [8:0]            msteps_r, msteps_nxt;
    logic                  rsv_err_r, rsv_err_nxt;

    // Decode; fields hold unless a driver control word arrives, except the step-off bit, which a power-stage word loads
    always_comb begin
        off_nxt       = off_r;
        pol_a_nxt     = pol_a_r;
        mag_a_nxt     = mag_a_r;
        pol_b_nxt     = pol_b_r;
        mag_b_nxt     = mag_b_r;
        interp_nxt    = interp_r;
        both_edge_nxt = both_edge_r;
        step_res_nxt  = step_res_r;
        rsv_err_nxt   = rsv_err_r;
        // Step-off bit lives in the power-stage word
        if (is_pwr_cfg) begin
            off_nxt = word_r[STEP_OFF_BIT];
        end
        if (is_drv_ctrl) begin
            if (off_r) begin
                // Current-command layout
                pol_a_nxt = word_r[POL_A_BIT];
                mag_a_nxt = word_r[MAG_A_HI:MAG_A_LO];
                pol_b_nxt = word_r[POL_B_BIT];
                mag_b_nxt = word_r[MAG_B_HI:MAG_B_LO];
            end else begin
                // Step-configuration layout
                interp_nxt  = word_r[INTERP_BIT];
                both_edge_nxt = word_r[BOTH_EDGE_BIT];
                step_res_nxt  = word_r[STEP_RES_HI:STEP_RES_LO];
                // Flag nonzero reserved bits; fields are still taken
                rsv_err_nxt = (|word_r[RSV_HI_HI:RSV_HI_LO]) ||
                              (|word_r[RSV_LO_HI:RSV_LO_LO]);
            end
        end
        // Microsteps per quarter period; codes above 8 treated as full step.
        // Worked from the registered code, so it trails that output a cycle.
        if (step_res_r > 4'h8) begin
            msteps_nxt = MSTEP_FULL;
        end else begin
            msteps_nxt = MSTEP_MAX >> step_res_r;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            off_r     <= STEP_OFF_RST;
            pol_a_r   <= 1'b0;
            mag_a_r   <= MAG_RST;
            pol_b_r   <= 1'b0;
            mag_b_r   <= MAG_RST;
            interp_r  <= 1'b0;
            both_edge_r <= 1'b0;
            step_res_r  <= STEP_RES_RST;
            msteps_r    <= MSTEP_MAX;
            rsv_err_r <= 1'b0;
        end else begin
            off_r     <= off_nxt;
            pol_a_r   <= pol_a_nxt;
            mag_a_r   <= mag_a_nxt;
            pol_b_r   <= pol_b_nxt;
            mag_b_r   <= mag_b_nxt;
            interp_r  <= interp_nxt;
            both_edge_r <= both_edge_nxt;
            step_res_r  <= step_res_nxt;
            msteps_r  <= msteps_nxt;
            rsv_err_r <= rsv_err_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs, straight from flops
    // ------------------------------------------------------------
    assign step_interface_off     = off_r;
    assign coil_a_polarity        = pol_a_r;
    assign coil_a_magnitude       = mag_a_r;
    assign coil_b_polarity        = pol_b_r;
    assign coil_b_magnitude       = mag_b_r;
    assign step_interpolate_en    = interp_r;
    assign both_edge_step         = both_edge_r;
    assign microstep_resolution   = step_res_r;
    assign microsteps_per_quarter = msteps_r;
    assign reserved_bits_err      = rsv_err_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_coil_a_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (is_drv_ctrl && off_r) |=> (mag_a_r == $past(word_r[MAG_A_HI:MAG_A_LO])))
        else $error("coil A magnitude not loaded");
    a_coil_b_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (is_drv_ctrl && off_r) |=> (mag_b_r == $past(word_r[MAG_B_HI:MAG_B_LO])))
        else $error("coil B magnitude not loaded");
    a_pol_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (is_drv_ctrl && off_r) |=> (pol_a_r == $past(word_r[POL_A_BIT])) &&
                                   (pol_b_r == $past(word_r[POL_B_BIT])))
        else $error("coil polarity not loaded");
    a_step_cfg_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (is_drv_ctrl && !off_r) |=> (interp_r == $past(word_r[INTERP_BIT])) &&
                                    (both_edge_r == $past(word_r[BOTH_EDGE_BIT])))
        else $error("step configuration not loaded");
    a_cur_keeps_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (is_drv_ctrl && off_r) |=> $stable(step_res_r) && $stable(interp_r))
        else $error("current word altered step configuration");
    a_step_keeps_cur: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (is_drv_ctrl && !off_r) |=> $stable(mag_a_r) && $stable(mag_b_r))
        else $error("step word altered coil currents");
    a_fields_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !is_drv_ctrl |=> $stable(mag_a_r) && $stable(step_res_r) && $stable(both_edge_r))
        else $error("fields changed without driver control word");
    a_mode_select: assert property (@(posedge ref_clk) disable iff (!rst_n)
        is_pwr_cfg |=> (off_r == $past(word_r[STEP_OFF_BIT])))
        else $error("step-off bit not taken");
    a_step_res_map: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ($past(step_res_r) == 4'h4) && $stable(step_res_r) |-> (msteps_r == 9'h010))
        else $error("microstep count wrong");
    // Word must be the shift register as it stood at the synced rise
    a_latch_strobe: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(cs_sync) |=> cs_rise_r && (word_r == $past(shift_r)) ##1 !cs_rise_r)
        else $error("word not latched once on chip select rise");
endmodule : drv_ctrl_decode

/* core/drv_ctrl_pkg.sv */
package drv_ctrl_pkg;
    // ------------------------------------------------------------
    // Word layout
    // ------------------------------------------------------------
    localparam int WORD_W        = 20;  // Bits kept per latched word
    localparam int ADDR_HI_BIT   = 19;  // Upper register select bit
    localparam int ADDR_LO_BIT   = 18;  // Lower register select bit
    localparam int SEL3_BIT      = 17;  // Third select bit, some registers
    // Current-command layout
    localparam int POL_A_BIT     = 17;
    localparam int MAG_A_HI      = 16;
    localparam int MAG_A_LO      = 9;
    localparam int POL_B_BIT     = 8;
    localparam int MAG_B_HI      = 7;
    localparam int MAG_B_LO      = 0;
    localparam int MAG_W         = 8;
    // Step-configuration layout
    localparam int INTERP_BIT    = 9;
    localparam int BOTH_EDGE_BIT = 8;
    localparam int STEP_RES_HI   = 3;
    localparam int STEP_RES_LO   = 0;
    localparam int STEP_RES_W    = 4;
    localparam int RSV_HI_HI     = 17;
    localparam int RSV_HI_LO     = 10;
    localparam int RSV_LO_HI     = 7;
    localparam int RSV_LO_LO     = 4;
    localparam int INTERP_FACTOR = 16;  // Internal microsteps per step pulse
    // Power-stage configuration word
    localparam logic [2:0] PWR_CFG_SEL  = 3'h7;  // Bits 19..17 = 111
    localparam int         STEP_OFF_BIT = 7;
    // Select codes
    localparam logic [1:0] DRV_CTRL_SEL = 2'h0;
    // Reset values and microstep counts
    localparam logic [MAG_W-1:0]      MAG_RST      = 8'h00;
    localparam logic [STEP_RES_W-1:0] STEP_RES_RST = 4'h0;
    localparam logic                  STEP_OFF_RST = 1'b0;
    localparam logic [8:0] MSTEP_FULL = 9'h001;  // Code 8 and above
    localparam logic [8:0] MSTEP_MAX  = 9'h100;  // Code 0, also the reset count
endpackage : drv_ctrl_pkg

/* core/sync2.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Two-flop level synchroniser
// ------------------------------------------------------------
module sync2 #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0  // Idle level of the input
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Level in and out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_r;  // Metastable stage, read only by s2
    logic [W-1:0] s2_r;  // Settled stage
    logic [W-1:0] s1_nxt;
    logic [W-1:0] s2_nxt;

    // Next values
    always_comb begin
        s1_nxt = d;
        s2_nxt = s1_r;
    end

    // Registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // Reset to the idle level, so no false edge follows reset
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
        end
    end

    assign q = s2_r;
endmodule : sync2

/* verif/spi_host_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Serial host that writes configuration words
// ------------------------------------------------------------
module spi_host_model (
    // Link pins toward the device
    output logic sck,
    output logic sck_rst_n,
    output logic chip_select_n,
    output logic sdi
);
    localparam realtime HALF = 62.5;  // Half of the 125 ns link period

    // Idle link: clock still, frame closed
    initial begin
        sck = 1'b0;
        sck_rst_n = 1'b0;
        chip_select_n = 1'b1;
        sdi = 1'b0;
    end

    // Link reset needs clock edges while low, so a few with no frame
    task automatic link_reset();
        sck_rst_n = 1'b0;
        repeat (3) begin
            #HALF sck = 1'b1;
            #HALF sck = 1'b0;
        end
        sck_rst_n = 1'b1;
    endtask : link_reset

    // One frame, n bits MSB first; odd start offset keeps phase unrelated
    task automatic send(input logic [31:0] w, input int n);
        int i;
        #3.7 chip_select_n = 1'b0;
        for (i = n - 1; i >= 0; i--) begin
            sdi = w[i];
            #HALF sck = 1'b1;
            #HALF sck = 1'b0;
        end
        #HALF chip_select_n = 1'b1;
        // Released line must not keep showing the last bit
        sdi = ~sdi;
    endtask : send
endmodule : spi_host_model

/* verif/tb.sv */
`timescale 1ns/1ps
module tb;
    import drv_ctrl_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic       ref_clk, rst_n, sck, sck_rst_n, chip_select_n, sdi;
    logic       pa, pb, ip, de, off, err;    // Design outputs
    logic [7:0] ma, mb;
    logic [3:0] mr;
    logic [8:0] mpq;
    logic       e_pa, e_pb, e_ip, e_de, e_off, e_err;  // Expected state
    logic [7:0] e_ma, e_mb;
    logic [3:0] e_mr;
    logic [8:0] e_mpq;
    integer     fails, n_checks, cycles, seed, i, v;
    logic [7:0] a_mag, b_mag;

    // ------------------------------------------------------------
    // Design and host
    // ------------------------------------------------------------
    drv_ctrl_decode dut (.ref_clk(ref_clk), .rst_n(rst_n), .sck(sck), .sck_rst_n(sck_rst_n),
        .chip_select_n(chip_select_n), .sdi(sdi), .coil_a_polarity(pa),
        .coil_a_magnitude(ma), .coil_b_polarity(pb), .coil_b_magnitude(mb),
        .step_interpolate_en(ip), .both_edge_step(de), .microstep_resolution(mr),
        .microsteps_per_quarter(mpq), .step_interface_off(off), .reserved_bits_err(err));
    spi_host_model host (.sck(sck), .sck_rst_n(sck_rst_n), .chip_select_n(chip_select_n),
        .sdi(sdi));

    // 200 MHz system clock
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // Reference model and checks
    // ------------------------------------------------------------
    task automatic apply(input logic [19:0] w);
        if (w[19:17] == 3'h7) begin
            e_off = w[7];  // Power-stage word gives only the mode bit
        end else if (w[19:18] == 2'h0 && e_off) begin
            {e_pa, e_ma, e_pb, e_mb} = w[17:0];
        end else if (w[19:18] == 2'h0) begin
            {e_ip, e_de, e_mr} = {w[9:8], w[3:0]};
            e_err = (w[17:10] != 0) || (w[7:4] != 0);
            e_mpq = (w[3:0] > 8) ? 9'h001 : (9'h100 >> w[3:0]);
        end
    endtask : apply

    task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic check_all();
        chk("step_interface_off", {8'h00, off}, {8'h00, e_off});
        chk("coil_a_polarity", {8'h00, pa}, {8'h00, e_pa});
        chk("coil_a_magnitude", {1'b0, ma}, {1'b0, e_ma});
        chk("coil_b_polarity", {8'h00, pb}, {8'h00, e_pb});
        chk("coil_b_magnitude", {1'b0, mb}, {1'b0, e_mb});
        chk("step_interpolate_en", {8'h00, ip}, {8'h00, e_ip});
        chk("both_edge_step", {8'h00, de}, {8'h00, e_de});
        chk("microstep_resolution", {5'h00, mr}, {5'h00, e_mr});
        chk("microsteps_per_quarter", mpq, e_mpq);
        chk("reserved_bits_err", {8'h00, err}, {8'h00, e_err});
    endtask : check_all

    // One frame, then settle well past the five-edge answer
    task automatic xfer(input logic [31:0] w, input int n);
        host.send(w, n);
        apply(w[19:0]);
        repeat (10) @(posedge ref_clk);
        check_all();
    endtask : xfer

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    // Hang guard, about three times the expected run
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 50000) begin
            fails = fails + 1;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        {fails, n_checks, cycles, seed} = {32'd0, 32'd0, 32'd0, 32'd39};
        {e_pa, e_pb, e_ip, e_de, e_off, e_err, e_ma, e_mb, e_mr} = '0;
        e_mpq = 9'h100;
        fork
            host.link_reset();
            begin
                repeat (16) @(posedge ref_clk);
                rst_n <= 1'b1;
            end
        join
        repeat (3) @(posedge ref_clk);
        check_all();
        $display("test reset_values done");
        // Every resolution code, random edge and interpolation bits
        for (i = 0; i < 16; i++) begin
            v = $random(seed);
            xfer({12'h000, v[1:0], 4'h0, i[3:0]}, 20);
        end
        xfer(32'h01103, 20);
        xfer(32'h00045, 20);
        xfer(32'h00207, 20);
        $display("test step_config done");
        xfer(32'hE0080, 20);
        // Coil currents; odd frames carry junk ahead of the word
        for (i = 0; i < 8; i++) begin
            v = $random(seed);
            a_mag = (i == 0 || v[7:0] > 248) ? 8'hF8 : v[7:0];
            b_mag = (v[15:8] > 248) ? 8'hF8 : v[15:8];
            xfer({v[31:20], 2'h0, v[16], a_mag, v[17], b_mag}, 20 + 4 * (i % 2));
        end
        $display("test coil_current done");
        xfer(32'h9A5A5, 20);
        xfer(32'hC1234, 20);
        $display("test other_registers done");
        // Back to step layout; coil fields must hold
        xfer(32'hE0000, 20);
        xfer(32'h00105, 20);
        $display("test layout_return done");
        // Reset in mid-run brings every field back to its reset value
        rst_n <= 1'b0;
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        {e_pa, e_pb, e_ip, e_de, e_off, e_err, e_ma, e_mb, e_mr} = '0;
        e_mpq = 9'h100;
        repeat (3) @(posedge ref_clk);
        check_all();
        xfer(32'h00086, 20);
        $display("test mid_reset done");
        report_and_stop();
    end
endmodule : tb
